// ===== jste_core.sv
`timescale 1ns/1ps
`default_nettype none
// Operation
// RULE_01: Branch-if-lower behaves as branch-if-carry-set
// RULE_02: Jump to register mode traps via 4
// RULE_03: Jump loads effective address, no limit
// RULE_04: Software keeps targets at even addresses
// RULE_05: Call pushes link, link gets PC
// RULE_06: Call PC coroutine swaps stack top
// RULE_07: Return: PC from reg, pop reg
// RULE_08: Decrement register, branch backward if nonzero
// RULE_09: Trap pushes status and PC, loads vector
// RULE_10: Emulator trap range vectors through 30/32
// RULE_11: General trap range vectors through 34/36
// RULE_12: Breakpoint trap vectors through 14/16
// RULE_13: Trap flags loaded from vector status
// RULE_14: Interrupt/trace return pops PC then status
// RULE_15: Push predecrements, pop postincrements by two
module jste_core
   import jste_pkg::*;
(
   input  wire logic        pclk,     // Clock
   input  wire logic        presetn,  // Async reset, low
   input  wire logic        psel,     // APB select
   input  wire logic        penable,  // APB enable
   input  wire logic        pwrite,   // APB write
   input  wire logic [7:0]  paddr,    // APB byte address
   input  wire logic [31:0] pwdata,   // APB write data
   output logic      [31:0] prdata,   // APB read data
   output logic             pready,   // APB ready
   output logic             pslverr,  // APB error
   output logic             irq       // Level interrupt
);
   import jste_pkg::*;

   jste_apb_req_s req;
   jste_state_e   st_r;
   logic [15:0]   regs_r [8];
   logic [15:0]   psw_r, instr_r, ea_r, tmp_r, vec_r;
   logic [JSTE_IRQ_BITS-1:0] ist_r, imsk_r, ev;
   logic          busy;
   logic          m_we;
   logic [15:0]   m_addr, m_wd, m_rd, b_rd;
   logic [2:0]    rn;
   logic [15:0]   sp, pc, rv;
   logic          wr_acc, rd_acc, go, mem_hit;
   logic [7:0]    moff;

   assign req    = '{sel: psel, en: penable, wr: pwrite,
                     addr: paddr, wdata: pwdata};
   assign wr_acc = req.sel && req.en && req.wr;
   assign rd_acc = req.sel && req.en && !req.wr;
   assign busy   = (st_r != JSTE_IDLE);
   assign pready = 1'b1;
   assign rn     = instr_r[2:0];
   assign sp     = regs_r[JSTE_REG_SP];
   assign pc     = regs_r[JSTE_REG_PC];
   assign moff   = req.addr - JSTE_A_MEM0;
   assign mem_hit = (req.addr >= JSTE_A_MEM0) &&
                    (req.addr < JSTE_A_MEM0 + 8'(4*JSTE_MEM_WORDS));
   assign go     = wr_acc && req.addr == JSTE_A_CTRL && req.wdata[0]
                   && !busy;
   // Call with link register differs from register field of rn
   assign rv     = regs_r[instr_r[8:6]];

   jste_mem #(.WORDS(JSTE_MEM_WORDS)) u_mem (
      .pclk   (pclk),
      .a_we   (m_we),
      .a_addr (m_addr),
      .a_wd   (m_wd),
      .a_rd   (m_rd),
      .b_we   (wr_acc && mem_hit && !busy),
      .b_addr ({8'h00, 1'b0, moff[7:2], 1'b0}),
      .b_wd   (req.wdata[15:0]),
      .b_rd   (b_rd)
   );

   // Memory port for the current step
   always_comb begin
      m_we   = 1'b0;
      m_addr = sp;
      m_wd   = 16'h0000;
      unique case (st_r)
         JSTE_PUSH1: begin
            m_we   = 1'b1;
            m_addr = sp - JSTE_WORD_STEP; // RULE_15
            m_wd   = (vec_r == 16'hFFFF) ? rv : psw_r;
         end
         JSTE_PUSH2: begin
            m_we   = 1'b1;
            m_addr = sp - JSTE_WORD_STEP; // RULE_15
            m_wd   = pc;
         end
         JSTE_VPC: m_addr = vec_r;
         JSTE_VPS: m_addr = vec_r + JSTE_WORD_STEP;
         default:  m_addr = sp;
      endcase
   end

   // Sequencer; vec_r all-ones marks a call rather than a trap
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_r  <= JSTE_IDLE;
         vec_r <= 16'h0000;
         tmp_r <= 16'h0000;
         ev    <= '0;
      end else begin
         ev <= '0;
         unique case (st_r)
            JSTE_IDLE: if (go) st_r <= JSTE_EXEC;
            JSTE_EXEC: begin
               st_r <= JSTE_IDLE;
               ev[JSTE_IRQ_DONE] <= 1'b1;
               if ((instr_r & JSTE_MSK_JUMP) == JSTE_OP_JUMP ||
                   (instr_r & JSTE_MSK_CALL) == JSTE_OP_CALL) begin
                  if (instr_r[5:3] == 3'd0) begin
                     vec_r <= JSTE_VEC_ILL; // RULE_02
                     st_r  <= JSTE_PUSH1;
                     ev    <= 3'b110;
                  end else if ((instr_r & JSTE_MSK_CALL)
                               == JSTE_OP_CALL) begin
                     tmp_r <= ea_r; // RULE_05
                     vec_r <= 16'hFFFF;
                     st_r  <= JSTE_PUSH1;
                     ev    <= '0;
                  end
               end else if ((instr_r & JSTE_MSK_EMUL) == JSTE_OP_EMUL) begin
                  vec_r <= JSTE_VEC_EMUL; // RULE_10
                  st_r  <= JSTE_PUSH1;
                  ev    <= 3'b010;
               end else if ((instr_r & JSTE_MSK_EMUL)
                            == JSTE_OP_TRAP) begin
                  vec_r <= JSTE_VEC_TRAP; // RULE_11
                  st_r  <= JSTE_PUSH1;
                  ev    <= 3'b010;
               end else if (instr_r == JSTE_OP_BRKPT) begin
                  vec_r <= JSTE_VEC_BRKPT; // RULE_12
                  st_r  <= JSTE_PUSH1;
                  ev    <= 3'b010;
               end else if ((instr_r & JSTE_MSK_RTS) == JSTE_OP_RTS) begin
                  st_r  <= JSTE_POP1;
                  ev    <= '0;
               end else if (instr_r == JSTE_OP_RET_INT ||
                            instr_r == JSTE_OP_RET_TRC) begin
                  st_r  <= JSTE_POP1; // RULE_14
                  ev    <= '0;
               end
            end
            JSTE_PUSH1: begin
               if (vec_r == 16'hFFFF) begin
                  st_r <= JSTE_IDLE; // RULE_05
                  ev[JSTE_IRQ_DONE] <= 1'b1;
               end else begin
                  st_r <= JSTE_PUSH2; // RULE_09
               end
            end
            JSTE_PUSH2: st_r <= JSTE_VPC;
            JSTE_VPC:   st_r <= JSTE_VPS;
            JSTE_VPS: begin
               st_r <= JSTE_IDLE;
               ev[JSTE_IRQ_DONE] <= 1'b1;
            end
            JSTE_POP1: begin
               if ((instr_r & JSTE_MSK_RTS) == JSTE_OP_RTS) begin
                  st_r <= JSTE_IDLE;
                  ev[JSTE_IRQ_DONE] <= 1'b1;
               end else begin
                  st_r <= JSTE_POP2;
               end
            end
            JSTE_POP2: begin
               st_r <= JSTE_IDLE;
               ev[JSTE_IRQ_DONE] <= 1'b1;
            end
            default: st_r <= JSTE_IDLE;
         endcase
      end
   end

   // General registers: bus writes when idle, core updates when busy
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         for (int i = 0; i < 8; i++) regs_r[i] <= JSTE_PC_RST;
      end else if (!busy) begin
         if (wr_acc && req.addr >= JSTE_A_REG0 && req.addr < JSTE_A_MEM0)
            regs_r[req.addr[4:2]] <= req.wdata[15:0];
         else if (wr_acc && req.addr == JSTE_A_PC)
            regs_r[JSTE_REG_PC] <= req.wdata[15:0];
      end else begin
         unique case (st_r)
            JSTE_EXEC: begin
               if ((instr_r & JSTE_MSK_BR) == JSTE_OP_BR_LOWER) begin
                  if (psw_r[JSTE_PSW_C]) // RULE_01
                     regs_r[JSTE_REG_PC] <= pc +
                        {{7{instr_r[7]}}, instr_r[7:0], 1'b0};
               end else if ((instr_r & JSTE_MSK_JUMP) == JSTE_OP_JUMP) begin
                  if (instr_r[5:3] != 3'd0)
                     regs_r[JSTE_REG_PC] <= ea_r; // RULE_03
               end else if ((instr_r & JSTE_MSK_SUB1BR) == JSTE_OP_SUB1BR)
               begin
                  regs_r[instr_r[8:6]] <= rv - 16'h0001; // RULE_08
                  if (rv != 16'h0001)
                     regs_r[JSTE_REG_PC] <= pc -
                        {9'h000, instr_r[5:0], 1'b0}; // RULE_08
               end else if ((instr_r & JSTE_MSK_RTS) == JSTE_OP_RTS) begin
                  regs_r[JSTE_REG_PC] <= regs_r[rn]; // RULE_07
               end
            end
            JSTE_PUSH1: begin
               regs_r[JSTE_REG_SP] <= sp - JSTE_WORD_STEP; // RULE_15
               if (vec_r == 16'hFFFF) begin
                  // Link gets PC, then PC the saved target
                  regs_r[instr_r[8:6]] <= pc; // RULE_05
                  regs_r[JSTE_REG_PC]  <= tmp_r; // RULE_06
               end
            end
            JSTE_PUSH2: regs_r[JSTE_REG_SP] <= sp - JSTE_WORD_STEP;
            JSTE_VPC:   regs_r[JSTE_REG_PC] <= m_rd; // RULE_09
            JSTE_POP1: begin
               regs_r[JSTE_REG_SP] <= sp + JSTE_WORD_STEP; // RULE_15
               if ((instr_r & JSTE_MSK_RTS) == JSTE_OP_RTS)
                  regs_r[rn] <= m_rd; // RULE_07
               else
                  regs_r[JSTE_REG_PC] <= m_rd; // RULE_14
            end
            JSTE_POP2: regs_r[JSTE_REG_SP] <= sp + JSTE_WORD_STEP;
            default: ;
         endcase
      end
   end

   // Status word, instruction and effective address
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         psw_r   <= JSTE_PSW_RST;
         instr_r <= 16'h0000;
         ea_r    <= 16'h0000;
      end else if (!busy) begin
         if (wr_acc && req.addr == JSTE_A_PSW)   psw_r   <= req.wdata[15:0];
         if (wr_acc && req.addr == JSTE_A_INSTR) instr_r <= req.wdata[15:0];
         if (wr_acc && req.addr == JSTE_A_EA)    ea_r    <= req.wdata[15:0];
      end else if (st_r == JSTE_VPS) begin
         psw_r <= m_rd; // RULE_13
      end else if (st_r == JSTE_POP2) begin
         psw_r <= m_rd; // RULE_14
      end
   end

   // Sticky events; a read clears, a same-cycle event survives
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ist_r  <= '0;
         imsk_r <= '0;
      end else begin
         if (rd_acc && req.addr == JSTE_A_IRQ_ST)
            ist_r <= ev;
         else
            ist_r <= ist_r | ev;
         if (wr_acc && req.addr == JSTE_A_IRQ_MSK)
            imsk_r <= req.wdata[JSTE_IRQ_BITS-1:0];
      end
   end

   assign irq = |(ist_r & imsk_r);

   // Unmapped addresses and writes while busy, except to the mask, answer with an error
   always_comb begin
      prdata  = 32'h0000_0000;
      pslverr = 1'b0;
      if (req.sel && req.en) begin
         if (req.addr == JSTE_A_CTRL)         prdata[0] = busy;
         else if (req.addr == JSTE_A_INSTR)   prdata[15:0] = instr_r;
         else if (req.addr == JSTE_A_EA)      prdata[15:0] = ea_r;
         else if (req.addr == JSTE_A_PC)      prdata[15:0] = pc;
         else if (req.addr == JSTE_A_PSW)     prdata[15:0] = psw_r;
         else if (req.addr == JSTE_A_STAT)    prdata[7:0] = st_r;
         else if (req.addr == JSTE_A_IRQ_ST)
            prdata[JSTE_IRQ_BITS-1:0] = ist_r;
         else if (req.addr == JSTE_A_IRQ_MSK)
            prdata[JSTE_IRQ_BITS-1:0] = imsk_r;
         else if (req.addr >= JSTE_A_REG0 && req.addr < JSTE_A_MEM0)
            prdata[15:0] = regs_r[req.addr[4:2]];
         else if (mem_hit)                    prdata[15:0] = b_rd;
         else                                 pslverr = 1'b1;
         if (req.wr && busy && req.addr != JSTE_A_IRQ_MSK)
            pslverr = 1'b1;
      end
   end
endmodule
`default_nettype wire

// ===== jste_core_sva.sv
`timescale 1ns/1ps
`default_nettype none
module jste_core_sva
   import jste_pkg::*;
(
   input  wire logic        pclk,     // Clock
   input  wire logic        presetn,  // Async reset, low
   input  wire logic        psel,     // APB select
   input  wire logic        penable,  // APB enable
   input  wire logic        pwrite,   // APB write
   input  wire logic [7:0]  paddr,    // APB byte address
   input  wire logic [31:0] pwdata,   // APB write data
   input  wire logic [31:0] prdata,   // APB read data
   input  wire logic        pready,   // APB ready
   input  wire logic        pslverr,  // APB error
   input  wire logic        irq       // Level interrupt
);
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   sequence s_acc;
      psel && penable;
   endsequence
   sequence s_rd;
      s_acc ##0 !pwrite;
   endsequence
   // Everything from 0x80 up lies outside the map
   sequence s_far;
      s_acc ##0 paddr[7];
   endsequence
   sequence s_mask_wr;
      s_acc ##0 pwrite && paddr == JSTE_A_IRQ_MSK;
   endsequence

   a_ready_high: assert property (s_acc |-> pready)
      else $error("ready low in access");
   a_unmapped_err: assert property (s_far |-> pslverr)
      else $error("unmapped access without error");
   a_unmapped_zero: assert property (s_far ##0 !pwrite |-> prdata == 32'h0)
      else $error("unmapped read not zero");
   a_upper_zero: assert property (s_rd |-> prdata[31:16] == 16'h0)
      else $error("upper read half not zero");
   a_mask_noerr: assert property (s_mask_wr |-> !pslverr)
      else $error("mask write refused");
   a_read_noerr: assert property (s_rd ##0 !paddr[7] |-> !pslverr)
      else $error("mapped read refused");
   a_mask_quiet: assert property
      (s_mask_wr ##0 pwdata[2:0] == 3'h0 |=> !irq)
      else $error("irq high with mask clear");
   a_irq_clear: assert property ($fell(irq) |-> $past(psel && penable
      && (pwrite ? paddr == JSTE_A_IRQ_MSK : paddr == JSTE_A_IRQ_ST)))
      else $error("irq fell without status read or mask write");
endmodule

bind jste_core jste_core_sva u_sva (
   .pclk    (pclk),
   .presetn (presetn),
   .psel    (psel),
   .penable (penable),
   .pwrite  (pwrite),
   .paddr   (paddr),
   .pwdata  (pwdata),
   .prdata  (prdata),
   .pready  (pready),
   .pslverr (pslverr),
   .irq     (irq)
);
`default_nettype wire

// ===== jste_core_tb.sv
`timescale 1ns/1ps
`default_nettype none
module jste_core_tb;
   import jste_pkg::*;
   localparam logic [7:0] A_SP = JSTE_A_REG0 + 8'd24;
   localparam logic [7:0] A_R5 = JSTE_A_REG0 + 8'd20;
   localparam logic [7:0] A_R3 = JSTE_A_REG0 + 8'd12;
   localparam logic [7:0] A_TOP = JSTE_A_MEM0 + 8'd40;
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, irq;
   logic        m_we, e;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata, seed, rv;
   logic [3:0]  m_idx;
   logic [15:0] m_wd, pc, x, ea;
   logic [15:0] img [16];
   int          errors, samples_checked, cyc;

   jste_core dut (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq));
   jste_sysmem mem (.pclk(pclk), .we(m_we), .idx(m_idx), .wd(m_wd),
      .img(img));

   initial begin
      pclk = 1'b0;
      forever #2.5 pclk = ~pclk;
   end

   task end_of_test;
      if (errors == 0 && samples_checked > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask

   always @(posedge pclk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         errors = errors + 1;
         end_of_test;
      end
   end

   function logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   function logic [15:0] f_br(input logic [15:0] p, input logic [7:0] o,
                              input logic c);
      return c ? p + {{7{o[7]}}, o, 1'b0} : p;
   endfunction
   function logic [15:0] f_sob(input logic [15:0] p, input logic [15:0] r,
                               input logic [5:0] o);
      return (r - 16'h1 != 16'h0) ? p - {9'h0, o, 1'b0} : p;
   endfunction

   task chk(input string n, input logic [31:0] ex, input logic [31:0] got);
      samples_checked++;
      if (got !== ex) begin
         errors++;
         $display("[ERR] %s expected %h seen %h", n, ex, got);
      end
   endtask
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
      rv = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask
   task wr(input logic [7:0] a, input logic [15:0] d);
      apb(1'b1, a, {16'h0, d});
   endtask
   task rdchk(input string n, input logic [7:0] a, input logic [31:0] ex);
      apb(1'b0, a, 32'h0);
      chk(n, ex, rv);
   endtask
   task wm(input int i, input logic [15:0] d);
      m_we <= 1'b1;
      m_idx <= i[3:0];
      m_wd <= d;
      @(posedge pclk);
      m_we <= 1'b0;
      wr(JSTE_A_MEM0 + 8'(4 * i), d);
   endtask
   task ld(input logic [15:0] p, input logic [15:0] s, input logic [15:0] ps);
      wr(JSTE_A_PC, p);
      wr(A_SP, s);
      wr(JSTE_A_PSW, ps);
   endtask
   task run(input logic [15:0] ins, input logic [15:0] ea_i, input logic poke);
      int k;
      wr(JSTE_A_INSTR, ins);
      wr(JSTE_A_EA, ea_i);
      wr(JSTE_A_CTRL, 16'h1);
      if (poke) begin
         wr(JSTE_A_REG0, 16'hFFFF);
         chk("busy_refuse", 1, e);
      end
      k = 0;
      rv = 32'h1;
      while (rv[0] !== 1'b0 && k < 40) begin
         apb(1'b0, JSTE_A_CTRL, 32'h0);
         k++;
      end
      chk("busy_end", 0, rv[0]);
   endtask
   // Stack top at 026: status lands at 024, return address at 022
   task trap(input logic [15:0] ins, input logic [15:0] vec,
             input logic [15:0] ret, input logic poke);
      int          vi;
      logic [15:0] p, s;
      seed = lfsr(seed);
      vi = int'(vec) >> 1;
      p = seed[15:0] & 16'hFFFE;
      s = {12'h0, seed[19:16]};
      ld(p, 16'o26, s);
      run(ins, 16'h0, poke);
      rdchk("trap_pc", JSTE_A_PC, img[vi]);
      rdchk("trap_ps", JSTE_A_PSW, img[vi + 1]);
      rdchk("trap_sp", A_SP, 16'o22);
      rdchk("stk_ps", A_TOP, s);
      rdchk("stk_pc", A_TOP - 8'd4, p);
      run(ret, 16'h0, 1'b0);
      rdchk("ret_pc", JSTE_A_PC, p);
      rdchk("ret_ps", JSTE_A_PSW, s);
      rdchk("ret_sp", A_SP, 16'o26);
   endtask

   initial begin
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h0;
      pwdata = 32'h0;
      m_we = 1'b0;
      m_idx = 4'h0;
      m_wd = 16'h0;
      presetn = 1'b0;
      errors = 0;
      samples_checked = 0;
      cyc = 0;
      seed = 32'hD708;
      repeat (12) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      for (int i = 0; i < JSTE_MEM_WORDS; i++) begin
         seed = lfsr(seed);
         wm(i, i[0] ? {12'h0, seed[3:0]} : seed[15:0] & 16'hFFFE);
      end
      for (int i = 0; i < 2; i++) begin
         wr(JSTE_A_IRQ_MSK, 16'(i));
         ld(16'h0100, 16'o26, 16'h0);
         run(JSTE_OP_BR_LOWER, 16'h0, 1'b0);
         chk("irq", i, irq);
         rdchk("irq_st", JSTE_A_IRQ_ST, 32'h1);
         chk("irq_clr", 0, irq);
      end
      apb(1'b0, 8'h80, 32'h0);
      chk("unmapped_err", 1, e);
      chk("unmapped_rd", 0, rv);
      for (int i = 0; i < 8; i++) begin
         seed = lfsr(seed);
         pc = seed[15:0] & 16'hFFFE;
         x = {8'h0, i == 0 ? 8'h80 : i == 1 ? 8'h7F : seed[23:16]};
         ld(pc, 16'o26, {15'h0, seed[24]});
         run(JSTE_OP_BR_LOWER | x, 16'h0, 1'b0);
         rdchk("blo_pc", JSTE_A_PC, f_br(pc, x[7:0], seed[24]));
         ea = seed[31:16] & 16'hFFFE;
         run(JSTE_OP_JUMP | 16'o10, ea, 1'b0);
         rdchk("jmp_pc", JSTE_A_PC, ea);
      end
      for (int i = 0; i < 4; i++) begin
         seed = lfsr(seed);
         pc = seed[15:0] & 16'hFFFE;
         x = i == 0 ? 16'h1 : i == 1 ? 16'h2 : seed[31:16];
         ld(pc, 16'o26, 16'h0);
         wr(A_R3, x);
         run(JSTE_OP_SUB1BR | 16'o300 | {10'h0, seed[21:16] | {6{i == 1}}},
             16'h0, 1'b0);
         rdchk("sob_reg", A_R3, x - 16'h1);
         rdchk("sob_pc", JSTE_A_PC,
               f_sob(pc, x, seed[21:16] | {6{i == 1}}));
      end
      seed = lfsr(seed);
      pc = seed[15:0] & 16'hFFFE;
      x = seed[31:16];
      ea = 16'(lfsr(seed)) & 16'hFFFE;
      ld(pc, 16'o26, 16'h0);
      wr(A_R5, x);
      run(JSTE_OP_CALL | 16'o537, ea, 1'b0);
      rdchk("jsr_pc", JSTE_A_PC, ea);
      rdchk("jsr_link", A_R5, pc);
      rdchk("jsr_stk", A_TOP, x);
      rdchk("jsr_sp", A_SP, 16'o24);
      run(JSTE_OP_RTS | 16'h5, 16'h0, 1'b0);
      rdchk("rts_pc", JSTE_A_PC, pc);
      rdchk("rts_reg", A_R5, x);
      rdchk("rts_sp", A_SP, 16'o26);
      // Addressing is outside the core: bench pops the top and passes it
      x = ea ^ 16'h0F0E;
      wm(10, x);
      ld(pc, 16'o26, 16'h0);
      run(JSTE_OP_CALL | 16'o736, x, 1'b0);
      rdchk("co_pc", JSTE_A_PC, x);
      rdchk("co_top", A_TOP, pc);
      rdchk("co_sp", A_SP, 16'o24);
      trap(JSTE_OP_EMUL | {8'h0, seed[7:0]}, JSTE_VEC_EMUL,
           JSTE_OP_RET_INT, 1'b1);
      trap(JSTE_OP_TRAP | {8'h0, seed[15:8]}, JSTE_VEC_TRAP,
           JSTE_OP_RET_TRC, 1'b0);
      trap(JSTE_OP_BRKPT, JSTE_VEC_BRKPT,
           JSTE_OP_RET_INT, 1'b0);
      trap(JSTE_OP_JUMP | {13'h0, seed[2:0]}, JSTE_VEC_ILL,
           JSTE_OP_RET_TRC, 1'b0);
      end_of_test;
   end
endmodule
`default_nettype wire

// ===== jste_mem.sv
`timescale 1ns/1ps
`default_nettype none
// Word memory for low vectors and stack; two ports, core has priority
module jste_mem #(
   parameter int WORDS = 16
) (
   input  wire logic        pclk,    // Clock
   input  wire logic        a_we,    // Core write
   input  wire logic [15:0] a_addr,  // Core byte address
   input  wire logic [15:0] a_wd,    // Core write data
   output logic      [15:0] a_rd,    // Core read data
   input  wire logic        b_we,    // Bus write
   input  wire logic [15:0] b_addr,  // Bus byte address
   input  wire logic [15:0] b_wd,    // Bus write data
   output logic      [15:0] b_rd     // Bus read data
);
   localparam int AW = $clog2(WORDS);
   logic [15:0] mem [WORDS];

   // Byte address bit 0 ignored: words only
   assign a_rd = mem[a_addr[AW:1]];
   assign b_rd = mem[b_addr[AW:1]];

   always_ff @(posedge pclk) begin
      if (a_we) begin
         mem[a_addr[AW:1]] <= a_wd;
      end else if (b_we) begin
         mem[b_addr[AW:1]] <= b_wd;
      end
   end
endmodule
`default_nettype wire

// ===== jste_pkg.sv
package jste_pkg;

   // Opcodes and masks (octal as printed)
   localparam logic [15:0] JSTE_OP_BR_LOWER = 16'o103400;
   localparam logic [15:0] JSTE_MSK_BR      = 16'o177400;
   localparam logic [15:0] JSTE_OP_JUMP     = 16'o000100;
   localparam logic [15:0] JSTE_MSK_JUMP    = 16'o177700;
   localparam logic [15:0] JSTE_OP_CALL     = 16'o004000;
   localparam logic [15:0] JSTE_MSK_CALL    = 16'o177000;
   localparam logic [15:0] JSTE_OP_RTS      = 16'o000200;
   localparam logic [15:0] JSTE_MSK_RTS     = 16'o177770;
   localparam logic [15:0] JSTE_OP_SUB1BR   = 16'o077000;
   localparam logic [15:0] JSTE_MSK_SUB1BR  = 16'o177000;
   localparam logic [15:0] JSTE_OP_EMUL     = 16'o104000;
   localparam logic [15:0] JSTE_OP_TRAP     = 16'o104400;
   localparam logic [15:0] JSTE_MSK_EMUL    = 16'o177400;
   localparam logic [15:0] JSTE_OP_BRKPT    = 16'o000003;
   localparam logic [15:0] JSTE_OP_RET_INT  = 16'o000002;
   localparam logic [15:0] JSTE_OP_RET_TRC  = 16'o000006;

   // Trap vectors
   localparam logic [15:0] JSTE_VEC_ILL     = 16'o000004;
   localparam logic [15:0] JSTE_VEC_BRKPT   = 16'o000014;
   localparam logic [15:0] JSTE_VEC_EMUL    = 16'o000030;
   localparam logic [15:0] JSTE_VEC_TRAP    = 16'o000034;
   localparam logic [15:0] JSTE_WORD_STEP   = 16'h0002;

   // Register numbers and PSW fields
   localparam logic [2:0]  JSTE_REG_SP      = 3'd6;
   localparam logic [2:0]  JSTE_REG_PC      = 3'd7;
   localparam int          JSTE_PSW_C       = 0;
   localparam int          JSTE_PSW_Z       = 2;
   localparam int          JSTE_PSW_N       = 3;

   // APB register map (byte addresses)
   localparam logic [7:0]  JSTE_A_CTRL      = 8'h00;
   localparam logic [7:0]  JSTE_A_INSTR     = 8'h04;
   localparam logic [7:0]  JSTE_A_EA        = 8'h08;
   localparam logic [7:0]  JSTE_A_PC        = 8'h0C;
   localparam logic [7:0]  JSTE_A_PSW       = 8'h10;
   localparam logic [7:0]  JSTE_A_STAT      = 8'h14;
   localparam logic [7:0]  JSTE_A_IRQ_ST    = 8'h18;
   localparam logic [7:0]  JSTE_A_IRQ_MSK   = 8'h1C;
   localparam logic [7:0]  JSTE_A_REG0      = 8'h20;
   localparam logic [7:0]  JSTE_A_MEM0      = 8'h40;
   localparam int          JSTE_MEM_WORDS   = 16;
   localparam int          JSTE_IRQ_BITS    = 3;
   localparam int          JSTE_IRQ_DONE    = 0;
   localparam int          JSTE_IRQ_TRAP    = 1;
   localparam int          JSTE_IRQ_ILL     = 2;
   localparam logic [15:0] JSTE_PC_RST      = 16'h0000;
   localparam logic [15:0] JSTE_PSW_RST     = 16'h0000;

   typedef struct packed {
      logic        sel;
      logic        en;
      logic        wr;
      logic [7:0]  addr;
      logic [31:0] wdata;
   } jste_apb_req_s;

   typedef enum logic [7:0] {
      JSTE_IDLE  = 8'b00000001,
      JSTE_EXEC  = 8'b00000010,
      JSTE_PUSH1 = 8'b00000100,
      JSTE_PUSH2 = 8'b00001000,
      JSTE_VPC   = 8'b00010000,
      JSTE_VPS   = 8'b00100000,
      JSTE_POP1  = 8'b01000000,
      JSTE_POP2  = 8'b10000000
   } jste_state_e;

endpackage

// ===== jste_sysmem.sv
`timescale 1ns/1ps
`default_nettype none
// Image of the low vector and stack words as software loaded them
module jste_sysmem (
   input  wire logic        pclk,     // Clock
   input  wire logic        we,       // Load strobe
   input  wire logic [3:0]  idx,      // Word index, byte address / 2
   input  wire logic [15:0] wd,       // Word to load
   output var  logic [15:0] img [16]  // Words as loaded
);
   // Whole words only: odd byte targets have no place here
   always_ff @(posedge pclk) begin
      if (we) begin
         img[idx] <= wd;
      end
   end
endmodule
`default_nettype wire
